// [verilog/ext_bus_pkg.sv]
// package: register map, field layout, states and pin carriers of the external bus controller
package ext_bus_pkg;

  // register indices; the apb byte address is four times the index
  localparam logic [7:0] IDX_PRESCALE    = 8'heb;
  localparam logic [7:0] IDX_MODE_ONE    = 8'hf5;
  localparam logic [7:0] IDX_MODE_TWO    = 8'hf6;
  localparam logic [7:0] IDX_STROBE_WAIT = 8'hfc;
  localparam logic [7:0] IDX_INT_VECTOR  = 8'hf2;
  localparam logic [7:0] IDX_STATUS      = 8'hf3;
  localparam int         APB_AW          = 12;

  // clock_prescale_and_float_ctl fields
  localparam int B_FLOAT  = 0;
  localparam int PRS_LO   = 2;
  localparam int PRS_W    = 3;
  // bus_mode_ctl_one fields
  localparam int B_DRIVE  = 1;
  localparam int B_DEMUX  = 3;
  localparam int B_SECOND = 5;
  localparam int B_STYLE  = 6;
  // bus_mode_ctl_two fields
  localparam int LAS_LO   = 0;
  localparam int UAS_LO   = 2;
  localparam int AW_W     = 2;
  localparam int B_BUS_EN = 4;
  // strobe_wait_ctl fields
  localparam int LDS_LO   = 0;
  localparam int UDS_LO   = 3;
  localparam int DW_W     = 3;
  // int_vector_reg field
  localparam int B_HOLD_EN = 0;
  // address bit that splits upper and lower block
  localparam int B_UPPER  = 21;

  // reset values: wait fields at their maxima
  localparam logic [7:0] RST_PRESCALE    = 8'h00;
  localparam logic [7:0] RST_MODE_ONE    = 8'h00;
  localparam logic [7:0] RST_MODE_TWO    = 8'h0f;
  localparam logic [7:0] RST_STROBE_WAIT = 8'h3f;
  localparam logic [7:0] RST_INT_VECTOR  = 8'h00;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_WAIT, ST_DATA, ST_DATA_WAIT} seq_state_t;

  // one external memory request from the core
  typedef struct packed {
    logic        write;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

  // external bus pins with their output enables
  typedef struct packed {
    logic [7:0] port0_o;
    logic       port0_oe;
    logic [7:0] port1_o;
    logic       port1_oe;
    logic [5:0] port2_o;
    logic       port2_oe;
    logic [7:0] port6_o;
    logic       port6_oe;
    logic       as_o;
    logic       ds_o;
    logic       ds2_o;
    logic       rw_o;
    logic       ctl_oe;
    logic       drive_strong;
  } bus_pins_t;

  // block decode, shared by sequencer and pin mapper
  function automatic logic is_upper(input logic [21:0] a);
    return a[B_UPPER];
  endfunction

endpackage

// [verilog/core_clock_gen.sv]
// core clock prescaler: divides mclk by 1..8 and freezes high during wait states
`timescale 1ns/1ns
`default_nettype none
module core_clock_gen import ext_bus_pkg::*; (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // control
  input  wire logic [PRS_W-1:0] div_sel,
  input  wire logic             stall,
  // outputs
  output logic                  tick,
  output logic                  core_clock
);

  logic [PRS_W-1:0] cnt_q;
  logic [PRS_W-1:0] cnt_d;
  logic [PRS_W:0]   hi_len;
  logic             last;

  // period end; >= tolerates a divider lowered mid-period
  assign last   = (cnt_q >= div_sel);
  assign tick   = last && !stall;
  assign hi_len = (PRS_W+1)'(({1'b0, div_sel} + 4'h2) >> 1);
  assign cnt_d  = stall ? cnt_q : (last ? '0 : cnt_q + 3'h1);

  // clock is high at the start of each period, so a frozen count keeps it high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q      <= '0;
      core_clock <= 1'b1;
    end else begin
      cnt_q      <= cnt_d;
      core_clock <= ({1'b0, cnt_d} < hi_len); // [R10] [R16]
    end
  end

endmodule
`default_nettype wire

// [verilog/bus_pin_map.sv]
// pin mapper: turns internal strobes and mode bits into registered bus pins
`timescale 1ns/1ns
`default_nettype none
module bus_pin_map import ext_bus_pkg::*; (
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     rst_b,
  // mode bits
  input  wire logic     style,
  input  wire logic     second,
  input  wire logic     demux,
  input  wire logic     flt,
  input  wire logic     drive,
  // cycle state
  input  wire mem_req_t req,
  input  wire logic     in_cycle,
  input  wire logic     addr_phase,
  input  wire logic     as_n,
  input  wire logic     ds_n,
  // pins
  output var bus_pins_t pins
);

  bus_pins_t pins_d;
  logic      wr;
  logic      rd;
  logic      strobe;

  // strobe and port decoding
  always_comb begin
    wr     = in_cycle && req.write;
    rd     = in_cycle && !req.write;
    pins_d = '0;
    strobe = style ? (rd ? ds_n : 1'b1) : ds_n; // [R02]
    pins_d.ds_o  = (second && !is_upper(req.addr)) ? 1'b1 : strobe; // [R05]
    pins_d.ds2_o = (second && is_upper(req.addr)) ? 1'b1 : (second ? strobe : 1'b1); // [R05]
    pins_d.rw_o  = style ? (wr ? ds_n : 1'b1) : !wr; // [R03] [R19]
    pins_d.as_o  = style ? !as_n : as_n; // [R01]
    // demuxed mode floats port 0 in the address phase
    pins_d.port0_o  = addr_phase ? req.addr[7:0] : req.wdata; // [R06] [R18]
    pins_d.port0_oe = !flt && in_cycle && (addr_phase ? !demux : req.write); // [R06] [R07]
    pins_d.port1_o  = req.addr[15:8];
    pins_d.port1_oe = !flt; // [R07]
    pins_d.port2_o  = req.addr[21:16];
    pins_d.port2_oe = !flt; // [R07]
    pins_d.port6_o  = req.addr[7:0];
    pins_d.port6_oe = !flt && demux; // [R06] [R07]
    pins_d.ctl_oe   = !flt; // [R07]
    pins_d.drive_strong = drive; // [R04]
  end

  // registered pins avoid glitches on the strobes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins       <= '0;
      pins.as_o  <= 1'b1;
      pins.ds_o  <= 1'b1;
      pins.ds2_o <= 1'b1;
      pins.rw_o  <= 1'b1;
    end else begin
      pins <= pins_d;
    end
  end

endmodule
`default_nettype wire

// [verilog/ext_bus_ctl.sv]
// external memory bus controller: apb registers, bus cycle sequencer and wait logic
//
// Overview of operation
// [R01] strobe-style bit set: address strobe pin outputs inverted strobe as latch enable.
// [R02] separate strobes: data strobe pin follows strobe on reads, stays high on writes.
// [R03] separate strobes: read/write pin follows strobe on writes, stays high on reads.
// [R04] drive strength bit selects small quiet or large strong pin buffers.
// [R05] second strobe enabled: primary serves upper block, second strobe lower block.
// [R06] demux bit moves low address byte to port 6; port 0 carries data only.
// [R07] float bit releases all ports and strobe pins to high impedance.
// [R08] software keeps float clear while external memory is being accessed.
// [R09] software sets bit 4 of second mode register before using the bus.
// [R10] bus timing follows core clock, internal clock divided by one to eight.
// [R11] address strobe stretched zero to three waits, per block field.
// [R12] data strobe stretched zero to seven waits, per block field.
// [R13] external hold input only counts while its enable bit is set.
// [R14] hold input sampled each clock; each active sample adds one cycle.
// [R15] hold in address phase stretches address strobe; in data phase, data strobe.
// [R16] waits count internal clocks; core clock stays high during them.
// [R17] all wait fields reset to maximum values.
// [R18] each cycle has an address phase followed by a data phase.
// [R19] read/write pin high for reads, low for writes.
// [R20] address bit 21 set selects upper block, clear selects lower block.
// [R21] on reads memory presents data before the data strobe rises.
// [R22] programmed waits and hold stretching add up within a phase.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctl import ext_bus_pkg::*; (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core request and answer
  input  wire logic              req_valid,
  input  wire mem_req_t          req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_rdata,
  // external bus
  input  wire logic [7:0]        port0_i,
  input  wire logic              ext_hold_req_n,
  output var bus_pins_t          pins,
  output logic                   core_clock
);

  logic [7:0] prescale_q;
  logic [7:0] mode_one_q;
  logic [7:0] mode_two_q;
  logic [7:0] strobe_wait_q;
  logic [7:0] int_vector_q;
  seq_state_t st_q;
  logic [3:0] cnt_q;
  logic       last_q;
  mem_req_t   req_q;
  logic [7:0] rd_val;
  logic [7:0] idx;
  logic       mapped;
  logic       wr_en;
  logic       upper;
  logic [1:0] aw;
  logic [2:0] dw;
  logic       hold_en;
  logic       hold_act;
  logic       wait_done;
  logic       last;
  logic       stall;
  logic       tick;
  logic       style;
  logic       second;
  logic       flt;
  logic       in_cycle;
  logic       addr_phase;

  // ---- apb decode ----
  // only word aligned addresses whose index fits the 8-bit map
  assign idx    = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[APB_AW-1:10] == 2'h0) &&
                  (idx == IDX_PRESCALE || idx == IDX_MODE_ONE || idx == IDX_MODE_TWO ||
                   idx == IDX_STROBE_WAIT || idx == IDX_INT_VECTOR || idx == IDX_STATUS);
  assign wr_en   = psel && penable && pwrite && mapped;
  // registers answer without wait; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read mux; status shows the sequencer's state and the hold input level
  always_comb begin
    case (idx)
      IDX_PRESCALE:    rd_val = prescale_q;
      IDX_MODE_ONE:    rd_val = mode_one_q;
      IDX_MODE_TWO:    rd_val = mode_two_q;
      IDX_STROBE_WAIT: rd_val = strobe_wait_q;
      IDX_INT_VECTOR:  rd_val = int_vector_q;
      IDX_STATUS:      rd_val = {4'h0, stall, addr_phase, in_cycle, !ext_hold_req_n};
      default:         rd_val = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= {24'h0, mapped ? rd_val : 8'h00};
    end
  end

  // register writes; status is read only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_q    <= RST_PRESCALE;
      mode_one_q    <= RST_MODE_ONE;
      mode_two_q    <= RST_MODE_TWO; // [R17]
      strobe_wait_q <= RST_STROBE_WAIT; // [R17]
      int_vector_q  <= RST_INT_VECTOR;
    end else if (wr_en) begin
      case (idx)
        IDX_PRESCALE:    prescale_q    <= pwdata[7:0];
        IDX_MODE_ONE:    mode_one_q    <= pwdata[7:0];
        IDX_MODE_TWO:    mode_two_q    <= pwdata[7:0];
        IDX_STROBE_WAIT: strobe_wait_q <= pwdata[7:0];
        IDX_INT_VECTOR:  int_vector_q  <= pwdata[7:0];
        default:         ;
      endcase
    end
  end

  // ---- mode and wait decoding ----
  assign style   = mode_one_q[B_STYLE];
  assign second  = mode_one_q[B_SECOND];
  assign flt     = prescale_q[B_FLOAT];
  assign upper   = is_upper(req_q.addr); // [R20]
  assign aw      = upper ? mode_two_q[UAS_LO +: AW_W] : mode_two_q[LAS_LO +: AW_W]; // [R11]
  assign dw      = upper ? strobe_wait_q[UDS_LO +: DW_W] : strobe_wait_q[LDS_LO +: DW_W]; // [R12]
  assign hold_en = int_vector_q[B_HOLD_EN];
  // the hold input is taken as synchronous to mclk
  assign hold_act = hold_en && !ext_hold_req_n; // [R13] [R14]

  // a wait phase ends on its last programmed cycle unless hold is still active
  assign wait_done = (cnt_q <= 4'h1) && !hold_act; // [R22]
  assign stall     = (st_q == ST_ADDR_WAIT) || (st_q == ST_DATA_WAIT); // [R16]
  assign in_cycle  = (st_q != ST_IDLE);
  assign addr_phase = (st_q == ST_ADDR) || (st_q == ST_ADDR_WAIT); // [R18]
  assign req_ready = (st_q == ST_IDLE);
  assign last = ((st_q == ST_DATA) && tick && (dw == 3'h0) && !hold_act) ||
                ((st_q == ST_DATA_WAIT) && wait_done);

  // core clock; waits freeze it high, so they count in mclk periods
  core_clock_gen u_clk (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .div_sel    (prescale_q[PRS_LO +: PRS_W]),
    .stall      (stall),
    .tick       (tick),
    .core_clock (core_clock)
  );

  // ---- cycle sequencer ----
  // a new cycle starts mid core period; the first address phase may be short
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (req_valid) begin
            st_q <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (tick) begin
            // a hold sample at the phase end adds one cycle on top of the programmed ones
            cnt_q <= {2'b00, aw} + {3'b000, hold_act}; // [R11] [R22]
            if (aw != 2'h0 || hold_act) begin // [R15]
              st_q <= ST_ADDR_WAIT;
            end else begin
              st_q <= ST_DATA; // [R18]
            end
          end
        end
        ST_ADDR_WAIT: begin
          // an active hold freezes the count, so its cycles add to the programmed ones
          if (cnt_q != 4'h0 && !hold_act) begin
            cnt_q <= cnt_q - 4'h1;
          end
          if (wait_done) begin // [R14] [R15]
            st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick) begin
            cnt_q <= {1'b0, dw} + {3'b000, hold_act}; // [R12] [R22]
            if (dw != 3'h0 || hold_act) begin // [R15]
              st_q <= ST_DATA_WAIT;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_DATA_WAIT: begin
          if (cnt_q != 4'h0 && !hold_act) begin
            cnt_q <= cnt_q - 4'h1;
          end
          if (wait_done) begin // [R14] [R22]
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // request is held for the whole cycle so pins stay stable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
    end else if (st_q == ST_IDLE && req_valid) begin
      req_q <= req;
    end
  end

  // answer: pins lag the state by one clock, so read data is taken one clock
  // after the last data cycle, while the strobe pin is still low, just before it rises
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      last_q    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      last_q    <= last;
      rsp_valid <= last_q;
      if (last_q && !req_q.write) begin
        rsp_rdata <= port0_i; // [R18] [R21]
      end
    end
  end

  // ---- pins ----
  bus_pin_map u_pins (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .style      (style),
    .second     (second),
    .demux      (mode_one_q[B_DEMUX]),
    .flt        (flt),
    .drive      (mode_one_q[B_DRIVE]),
    .req        (req_q),
    .in_cycle   (in_cycle),
    .addr_phase (addr_phase),
    .as_n       (!addr_phase),
    .ds_n       (!((st_q == ST_DATA) || (st_q == ST_DATA_WAIT))),
    .pins       (pins)
  );

  // ---- checks ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_as_three;
    (st_q == ST_ADDR_WAIT) [*3] ##1 (st_q == ST_DATA);
  endsequence

  sequence s_ds_seven;
    (st_q == ST_DATA_WAIT) [*7] ##1 (st_q == ST_IDLE);
  endsequence

  AST_AS_STRETCH: assert property ( // [R11]
    (st_q == ST_ADDR && tick && aw == 2'h3 && !hold_en) |=> s_as_three)
    else $error("address strobe not stretched by three waits");

  AST_DS_STRETCH: assert property ( // [R12]
    (st_q == ST_DATA && tick && dw == 3'h7 && !hold_en) |=> s_ds_seven)
    else $error("data strobe not stretched by seven waits");

  AST_HOLD_IGNORED: assert property ( // [R13]
    (st_q == ST_ADDR_WAIT && cnt_q <= 3'h1 && !hold_en) |=> (st_q == ST_DATA))
    else $error("hold input honoured while disabled");

  AST_HOLD_STRETCH: assert property ( // [R14]
    (st_q == ST_DATA_WAIT && cnt_q == 3'h0 && hold_act) |=> (st_q == ST_DATA_WAIT))
    else $error("active hold sample did not stretch the data strobe");

  AST_CLK_HIGH: assert property ( // [R16]
    (stall && $past(stall)) |-> core_clock)
    else $error("core clock low during wait states");

  AST_ALE: assert property ( // [R01]
    (style && st_q == ST_ADDR) |=> pins.as_o)
    else $error("latch enable not high in address phase");

  AST_OE_WRITE: assert property ( // [R02]
    (style && st_q == ST_DATA && req_q.write) |=> (pins.ds_o && pins.ds2_o))
    else $error("output enable active during write");

  AST_WE_READ: assert property ( // [R03]
    (style && st_q == ST_DATA && !req_q.write) |=> pins.rw_o)
    else $error("write enable active during read");

  AST_SECOND: assert property ( // [R05]
    (second && !style && st_q == ST_DATA && !req_q.write && upper) |=> (!pins.ds_o && pins.ds2_o))
    else $error("upper block access used the wrong strobe");

  AST_FLOAT: assert property ( // [R07]
    flt |=> (!pins.port0_oe && !pins.port1_oe && !pins.port6_oe && !pins.ctl_oe))
    else $error("bus driven while float bit set");

  AST_RW_LEVEL: assert property ( // [R19]
    (!style && in_cycle) |=> (pins.rw_o == !$past(req_q.write)))
    else $error("read/write pin level wrong");

endmodule
`default_nettype wire

// [verif/ext_mem_model.sv]
// external byte memory with address latch, answering reads on port 0
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model import ext_bus_pkg::*; (
  // clock and wiring options
  input  wire logic       mclk,
  input  wire logic       style,
  input  wire logic       demux,
  input  wire logic [2:0] lag,
  // bus pins
  input  wire bus_pins_t  pins,
  output logic [7:0]      port0_i
);
  logic [7:0] mem [256];
  logic [7:0] lat;
  logic [7:0] last = 8'h00;
  logic [2:0] age  = 3'h0;
  logic       ale, sel, rd, wr;

  // strobe decode; in latch-enable style the write enable alone strobes
  assign ale = pins.ctl_oe && pins.as_o == style;
  assign sel = !pins.ds_o || !pins.ds2_o;
  assign rd  = pins.ctl_oe && sel && pins.rw_o;
  assign wr  = pins.ctl_oe && !pins.rw_o && (style || sel);
  // undriven bus toggles so a late sample never sees stale data
  assign port0_i = (rd && age >= lag) ? mem[lat] : ~last;

  // latch address, store writes, age the read strobe for slow answers
  always_ff @(posedge mclk) begin
    if (ale) lat <= demux ? pins.port6_o : pins.port0_o;
    if (wr && pins.port0_oe) mem[lat] <= pins.port0_o;
    age  <= rd ? age + ((age == 3'h7) ? 3'h0 : 3'h1) : 3'h0;
    last <= port0_i;
  end
endmodule
`default_nettype wire

// [verif/ext_bus_ctl_tb_top.sv]
// self-checking bench for the external memory bus controller
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctl_tb_top import ext_bus_pkg::*;;
  logic              mclk, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic              req_valid = 1'b0, hold_n = 1'b1, mon = 1'b0, e;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, r;
  logic              pready, pslverr, req_ready, rsp_valid, core_clock;
  logic [7:0]        rsp_rdata, port0_i, m1 = 8'h00;
  logic [2:0]        lag = 3'h0;
  mem_req_t          req = '0;
  bus_pins_t         pins;
  int                err_total = 0, compares = 0, cyc = 0, lat, hi = 0, hi_max = 0;
  int                cnt [5]; // as active, ds low, ds2 low, rw low, port0 driven in as

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ext_bus_ctl dut_u (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .port0_i(port0_i), .ext_hold_req_n(hold_n), .pins(pins),
    .core_clock(core_clock));
  ext_mem_model mem_u (.mclk(mclk), .style(m1[B_STYLE]), .demux(m1[B_DEMUX]),
    .lag(lag), .pins(pins), .port0_i(port0_i));

  // pin activity, sampled mid-cycle where the registered pins are settled
  always @(negedge mclk) begin
    if (mon) begin
      cnt[0] += int'(pins.as_o == m1[B_STYLE]);
      cnt[1] += int'(!pins.ds_o);
      cnt[2] += int'(!pins.ds2_o);
      cnt[3] += int'(!pins.rw_o);
      cnt[4] += int'(pins.port0_oe && pins.as_o == m1[B_STYLE]);
    end
    hi = core_clock ? hi + 1 : 0;
    if (hi > hi_max) hi_max = hi;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, entered just after an edge; an idle cycle follows
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(r, {24'h000000, exp});
  endtask

  // mode write, mirrored for the memory wiring, then let the pins follow
  task automatic mode(input logic [7:0] v);
    apb(1'b1, IDX_MODE_ONE, v);
    m1 <= v;
    @(posedge mclk);
  endtask

  // one bus cycle; hold request held active for the first hw samples
  task automatic op(input logic w, input logic [21:0] a, input logic [7:0] d, input int hw);
    int n;
    cnt = '{default: 0};
    mon = 1'b1;
    req_valid <= 1'b1;
    req <= '{write: w, addr: a, wdata: d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    hold_n <= (hw == 0);
    lat = 0;
    do begin
      @(posedge mclk);
      lat++;
      if (lat == hw) hold_n <= 1'b1;
    end while (rsp_valid !== 1'b1 && lat < 300);
    mon = 1'b0;
    @(posedge mclk);
  endtask

  // main sequence
  initial begin
    int  n;
    logic prev;
    cnt = '{default: 0};
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdc(IDX_PRESCALE, RST_PRESCALE);
    rdc(IDX_MODE_ONE, RST_MODE_ONE);
    rdc(IDX_MODE_TWO, RST_MODE_TWO);
    rdc(IDX_STROBE_WAIT, RST_STROBE_WAIT);
    rdc(IDX_INT_VECTOR, RST_INT_VECTOR);
    apb(1'b0, 8'h00, 8'h00);
    chk(e, 1);
    chk(r, 0);
    apb(1'b1, IDX_MODE_TWO, 8'h1f);
    chk(pins.drive_strong, 0);
    // slowest timing out of reset: three address and seven data waits
    op(1'b1, 22'h000011, 8'h5a, 0);
    chk(lat, 14);
    chk(cnt[0], 4);
    chk(cnt[1], 8);
    chk(cnt[3] > 0, 1);
    chk(cnt[4] > 0, 1);
    op(1'b0, 22'h000011, 8'h00, 0);
    chk(rsp_rdata, 8'h5a);
    chk(cnt[3], 0);
    // lower block one/two waits, upper block three/seven
    apb(1'b1, IDX_MODE_TWO, 8'h1d);
    apb(1'b1, IDX_STROBE_WAIT, 8'h3a);
    op(1'b1, 22'h000022, 8'h3c, 0);
    chk(lat, 7);
    chk(cnt[0], 2);
    chk(cnt[1], 3);
    op(1'b1, 22'h200033, 8'hc3, 0);
    chk(lat, 14);
    chk(cnt[0], 4);
    // slow memory needs exactly the two programmed data waits
    lag <= 3'h2;
    op(1'b0, 22'h000022, 8'h00, 0);
    chk(rsp_rdata, 8'h3c);
    lag <= 3'h0;
    op(1'b0, 22'h200033, 8'h00, 0);
    chk(rsp_rdata, 8'hc3);
    // external hold: ignored, then stretching the address strobe
    apb(1'b1, IDX_MODE_TWO, 8'h10);
    apb(1'b1, IDX_STROBE_WAIT, 8'h00);
    op(1'b0, 22'h000022, 8'h00, 2);
    chk(lat, 4);
    apb(1'b1, IDX_INT_VECTOR, 8'h01);
    op(1'b0, 22'h000022, 8'h00, 2);
    chk(lat, 6);
    chk(cnt[0], 3);
    apb(1'b1, IDX_MODE_TWO, 8'h11);
    op(1'b0, 22'h000022, 8'h00, 2);
    chk(lat, 7);
    chk(cnt[0], 4);
    apb(1'b1, IDX_INT_VECTOR, 8'h00);
    apb(1'b1, IDX_MODE_TWO, 8'h10);
    // second strobe splits the blocks
    mode(8'h20);
    op(1'b1, 22'h200044, 8'h44, 0);
    chk(cnt[1], 1);
    chk(cnt[2], 0);
    op(1'b1, 22'h000055, 8'h55, 0);
    chk(cnt[1], 0);
    chk(cnt[2], 1);
    op(1'b0, 22'h000055, 8'h00, 0);
    chk(rsp_rdata, 8'h55);
    op(1'b0, 22'h200044, 8'h00, 0);
    chk(rsp_rdata, 8'h44);
    chk(cnt[2], 0);
    // latch-enable style with separate read and write enables
    mode(8'h40);
    chk(pins.as_o, 0);
    op(1'b1, 22'h000066, 8'h66, 0);
    chk(cnt[0], 1);
    chk(cnt[1], 0);
    chk(cnt[3], 1);
    op(1'b0, 22'h000066, 8'h00, 0);
    chk(rsp_rdata, 8'h66);
    chk(cnt[1], 1);
    chk(cnt[3], 0);
    // separate address byte and strong buffers
    mode(8'h0a);
    chk(pins.drive_strong, 1);
    op(1'b1, 22'h000077, 8'h77, 0);
    op(1'b0, 22'h000077, 8'h00, 0);
    chk(rsp_rdata, 8'h77);
    chk(cnt[4], 0);
    // divide by four: ten core clock rises in forty cycles
    apb(1'b1, IDX_PRESCALE, 8'h0c);
    n = 0;
    prev = core_clock;
    repeat (40) begin
      @(negedge mclk);
      n += int'(core_clock && !prev);
      prev = core_clock;
    end
    chk(n, 10);
    apb(1'b1, IDX_STROBE_WAIT, 8'h3f);
    hi_max = 0;
    op(1'b0, 22'h200033, 8'h00, 0);
    chk(hi_max >= 8, 1);
    // float releases every bus pin; cleared again before the next access
    apb(1'b1, IDX_PRESCALE, 8'h01);
    @(posedge mclk);
    chk({pins.port0_oe, pins.port1_oe, pins.port2_oe, pins.port6_oe, pins.ctl_oe}, 0);
    apb(1'b1, IDX_PRESCALE, 8'h00);
    op(1'b0, 22'h000077, 8'h00, 0);
    chk(rsp_rdata, 8'h77);
    final_report();
  end
endmodule
`default_nettype wire
